// *** rtl/stp_pkg.sv ***
// Purpose: Shared constants of the stepper driver register set
// Assumes: Word registers on Wishbone, byte address = index * 4
// Notes:   Offsets below are register indices

package stp_pkg;
  // Register indices
  localparam logic [6:0] IDX_CHOP   = 7'h6c;
  localparam logic [6:0] IDX_COOL   = 7'h6d;
  localparam logic [6:0] IDX_ACOM   = 7'h6e;
  localparam logic [6:0] IDX_DRV    = 7'h6f;
  localparam logic [6:0] IDX_VCHP   = 7'h70;
  localparam logic [6:0] IDX_SCALE  = 7'h71;
  localparam logic [6:0] IDX_AUTO   = 7'h72;
  localparam logic [6:0] IDX_SKIP   = 7'h73;
  localparam logic [6:0] IDX_VMIN   = 7'h74;
  localparam logic [6:0] IDX_HVTH   = 7'h75;
  localparam logic [6:0] IDX_ISTAT  = 7'h76;
  localparam logic [6:0] IDX_IMASK  = 7'h77;
  // Reset values
  localparam logic [31:0] CHOP_RST  = 32'h1041_0150;
  localparam logic [31:0] VCHP_RST  = 32'hc40c_001e;
  // Field positions
  localparam int TON_HI   = 9;
  localparam int SG_LO    = 16;
  localparam int SG_HI    = 23;
  localparam int SG_SHIFT = 4;
  localparam int HVFS_BIT = 23;
  localparam int HVCH_BIT = 24;
  localparam int VEL_W    = 23;
  localparam int SKIP_W   = 20;
  localparam int ONT_W    = 12;
  // Interrupt status bits
  localparam int INT_STALL = 0;
  localparam int INT_COMM  = 1;
  localparam int INT_SKIP  = 2;
  localparam int INT_W     = 3;
  // Sine table shape
  localparam real LUT_AMP  = 248.0;
  localparam real LUT_LEN  = 1024.0;
  localparam logic [9:0] PHASE_B_OFS = 10'h100;
endpackage

// *** rtl/stp_regs.sv ***
// Purpose: Driver register set with commutation timing and step accounting
// Assumes: One 10 MHz clock, pins synchronised here
// Notes:   Wishbone classic slave, one wait state per access
//
// What this block does
// - Load-speed mode on when enable pin high or velocity reaches minimum threshold.
// - On-time limit bits 9:0 give commutation on-time limit in clock periods.
// - Stall on-time bits 23:16 times 16 clocks; zero disables detection.
// - Stall detection stays active above high threshold with fullstep option.
// - Duty cycle bits 7:0 readable, 255 maximum, scales sine currents.
// - Bits 24:16 hold signed automatic duty offset, -255 to +255.
// - Auto register reports offset in bits 7:0, gradient in 23:16.
// - In load-speed mode count steps arriving while load output is low.
// - Skipped-step counter is 20 bits, up or down by direction, wraps.
// - Skipped-step counter only runs with step/dir mode select at one.
// - Chopper config is 32-bit read/write with its reset default.
// - Voltage chopper config is 22-bit write-only with its reset default.
// - Default sine entries are round(248*sin(2pi*i/1024+pi/1024))-1.
// - Rounding for the sine table is half up.
// - Phase currents come from the sine table, phase B 256 positions later.
//
// Local design decision: register access over Wishbone.

`timescale 1ns/1ps
`default_nettype none

module stp_regs
  import stp_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_b,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [8:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output var  logic [31:0]         wb_dat_o,
  output var  logic                wb_ack_o,
  // Pins
  input  wire logic                step_pin,
  input  wire logic                dir_pin,
  input  wire logic                load_speed_enable_pin,
  input  wire logic                step_dir_mode_select,
  // Internal chopper and regulator signals
  input  wire logic                pwm_on,
  input  wire logic                load_speed_output,
  input  wire logic [stp_pkg::VEL_W-1:0] actual_velocity,
  input  wire logic [7:0]          duty_cycle_sum,
  input  wire logic [8:0]          duty_offset_auto,
  input  wire logic [7:0]          auto_amplitude_offset,
  input  wire logic [7:0]          auto_amplitude_gradient,
  input  wire logic [31:0]         driver_status_in,
  // Configuration outputs
  output var  logic [31:0]         chopper_config,
  output var  logic [24:0]         load_adaptive_current_cfg,
  output var  logic [21:0]         voltage_chopper_cfg,
  // Drive outputs
  output var  logic                load_speed_active,
  output var  logic                commutation_limit,
  output var  logic                stall_detected,
  output var  logic signed [8:0]   phase_a_current,
  output var  logic signed [8:0]   phase_b_current,
  output var  logic signed [8:0]   scaled_a,
  output var  logic signed [8:0]   scaled_b,
  output var  logic [9:0]          microstep_pos,
  output var  logic                irq
);

  // Default sine quarter, fixed at elaboration
  function automatic logic signed [8:0] sine_val(input int i);
    real r;
    r = LUT_AMP * $sin(2.0 * 3.14159265358979 * i / LUT_LEN + 3.14159265358979 / LUT_LEN);
    return 9'(int'($floor(r + 0.5)) - 1);
  endfunction

  logic signed [8:0] sine_lut [256];
  for (genvar g = 0; g < 256; g++)
  begin : g_lut
    localparam logic signed [8:0] LUT_VAL = sine_val(g); // Real maths stays at elaboration
    assign sine_lut[g] = LUT_VAL;
  end

  // Registers
  logic [23:0]        acom_cfg;
  logic [VEL_W-1:0]   vmin_cfg;
  logic [24:0]        hvel_cfg;
  logic [INT_W-1:0]   int_status;
  logic [INT_W-1:0]   int_mask;
  logic [SKIP_W-1:0]  skipped;
  logic [ONT_W-1:0]   on_cnt;
  logic [3:0]         s1, s2, s3, pin_q;
  logic               step_prev;
  logic               step_edge;
  logic               above_high;
  logic               stall_ok;
  logic [ONT_W-1:0]   sg_limit;
  logic               comm_evt, stall_evt, skip_evt;
  logic               acc;
  logic               wr;
  logic [6:0]         idx;
  logic [31:0]        next_rdata;

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i;
  assign idx = wb_adr_i[8:2];

  // Three-stage pin synchroniser; second and third must agree
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1    <= 4'h0;
      s2    <= 4'h0;
      s3    <= 4'h0;
      pin_q <= 4'h0;
    end
    else
    begin
      s1 <= {step_dir_mode_select, load_speed_enable_pin, dir_pin, step_pin};
      s2 <= s1;
      s3 <= s2;
      for (int b = 0; b < 4; b++)
        if (s2[b] == s3[b])
          pin_q[b] <= s3[b];
    end
  end

  // Step edge from filtered pin
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      step_prev <= 1'b0;
    else
      step_prev <= pin_q[0];
  end
  assign step_edge = pin_q[0] && !step_prev;

  // Load-speed mode enable, pin or velocity threshold
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      load_speed_active <= 1'b0;
    else
      load_speed_active <= pin_q[2] || (vmin_cfg != '0 && actual_velocity >= vmin_cfg);
  end

  // Stall monitor gating above the high threshold
  assign above_high = hvel_cfg[VEL_W-1:0] != '0 && actual_velocity >= hvel_cfg[VEL_W-1:0];
  assign stall_ok   = acom_cfg[SG_HI:SG_LO] != 8'h00 && (!above_high || hvel_cfg[HVFS_BIT]);
  assign sg_limit   = {acom_cfg[SG_HI:SG_LO], 4'h0};

  // On-time counter, saturating, restarts each off phase
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      on_cnt <= '0;
    else if (!pwm_on || !load_speed_active)
      on_cnt <= '0;
    else if (on_cnt != '1)
      on_cnt <= on_cnt + 1'b1;
  end

  // Limit flags are one-cycle pulses, registered when the on-time count equals the limit
  assign comm_evt  = load_speed_active && pwm_on && on_cnt == {2'b00, acom_cfg[TON_HI:0]};
  assign stall_evt = load_speed_active && pwm_on && stall_ok && on_cnt == sg_limit;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      commutation_limit <= 1'b0;
      stall_detected    <= 1'b0;
    end
    else
    begin
      commutation_limit <= comm_evt;
      stall_detected    <= stall_evt;
    end
  end

  // Microstep position; held while steps are being skipped
  assign skip_evt = step_edge && load_speed_active && !load_speed_output;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      microstep_pos <= 10'h000;
    else if (step_edge && !skip_evt)
      microstep_pos <= pin_q[1] ? microstep_pos - 1'b1 : microstep_pos + 1'b1;
  end

  // Skipped-step counter, wraps naturally at 20 bits
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      skipped <= '0;
    else if (skip_evt && pin_q[3])
      skipped <= pin_q[1] ? skipped - 1'b1 : skipped + 1'b1;
  end

  // Table lookup by quarter symmetry
  function automatic logic signed [8:0] wave(input logic [9:0] p);
    logic [7:0] i;
    logic signed [8:0] v;
    i = p[8] ? ~p[7:0] : p[7:0];
    v = sine_lut[i];
    return p[9] ? ~v : v;
  endfunction

  // Phase currents and duty scaling; 255 is near full scale
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_a_current <= '0;
      phase_b_current <= '0;
      scaled_a        <= '0;
      scaled_b        <= '0;
    end
    else
    begin
      phase_a_current <= wave(microstep_pos);
      phase_b_current <= wave(microstep_pos + PHASE_B_OFS);
      scaled_a <= 9'((18'(phase_a_current) * $signed({1'b0, duty_cycle_sum})) >>> 8);
      scaled_b <= 9'((18'(phase_b_current) * $signed({1'b0, duty_cycle_sum})) >>> 8);
    end
  end

  // Configuration writes, byte lanes honoured for chopper config only; other words written whole on any lane
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chopper_config            <= CHOP_RST;
      load_adaptive_current_cfg <= '0;
      acom_cfg                  <= '0;
      voltage_chopper_cfg       <= VCHP_RST[21:0];
      vmin_cfg                  <= '0;
      hvel_cfg                  <= '0;
      int_mask                  <= '0;
    end
    else if (wr)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wb_sel_i[b])
        begin
          case (idx)
            IDX_CHOP:  chopper_config[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            IDX_COOL:  load_adaptive_current_cfg <= wb_dat_i[24:0];
            IDX_ACOM:  acom_cfg <= wb_dat_i[23:0];
            IDX_VCHP:  voltage_chopper_cfg <= wb_dat_i[21:0];
            IDX_VMIN:  vmin_cfg <= wb_dat_i[VEL_W-1:0];
            IDX_HVTH:  hvel_cfg <= wb_dat_i[24:0];
            IDX_IMASK: int_mask <= wb_dat_i[INT_W-1:0];
            default:   ;
          endcase
        end
      end
    end
  end

  // Sticky events; a new event wins over the clearing write
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      int_status <= '0;
    else
    begin
      int_status <= (int_status & ~((wr && idx == IDX_ISTAT && wb_sel_i[0]) ? wb_dat_i[INT_W-1:0] : '0))
                    | {skip_evt && pin_q[3], comm_evt, stall_evt};
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(int_status & int_mask);
  end

  // Read mux; write-only and unmapped words read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (idx)
      IDX_CHOP:  next_rdata = chopper_config;
      IDX_DRV:   next_rdata = driver_status_in;
      IDX_SCALE: next_rdata = {7'h00, duty_offset_auto, 8'h00, duty_cycle_sum};
      IDX_AUTO:  next_rdata = {8'h00, auto_amplitude_gradient, 8'h00, auto_amplitude_offset};
      IDX_SKIP:  next_rdata = {12'h000, skipped};
      IDX_VMIN:  next_rdata = {9'h000, vmin_cfg};
      IDX_HVTH:  next_rdata = {7'h00, hvel_cfg};
      IDX_ISTAT: next_rdata = {29'h0, int_status};
      IDX_IMASK: next_rdata = {29'h0, int_mask};
      default:   next_rdata = 32'h0000_0000;
    endcase
  end

  // One wait state, ack drops the cycle after
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= (acc && !wb_we_i) ? next_rdata : 32'h0000_0000;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_pin_enable_mode: assert property (pin_q[2] |=> load_speed_active)
    else $error("load-speed mode not enabled by pin");
  a_comm_on_time: assert property (load_speed_active && pwm_on && on_cnt == {2'b00, acom_cfg[TON_HI:0]}
    |=> commutation_limit)
    else $error("commutation limit missed");
  a_stall_zero_off: assert property (acom_cfg[SG_HI:SG_LO] == 8'h00 |=> !stall_detected)
    else $error("stall flagged while disabled");
  a_stall_high_vel: assert property (above_high && !hvel_cfg[HVFS_BIT] |=> !stall_detected)
    else $error("stall flagged above high velocity");
  a_skip_count_dir: assert property (skip_evt && pin_q[3] && !pin_q[1] |=> skipped == $past(skipped) + 1'b1)
    else $error("skipped counter did not count up");
  a_skip_mode_gate: assert property (!pin_q[3] |=> $stable(skipped))
    else $error("skipped counter moved outside step mode");
  a_chop_readback: assert property (acc && !wb_we_i && idx == IDX_CHOP |=> wb_dat_o == chopper_config)
    else $error("chopper config readback wrong");
  a_chop_write: assert property (wr && idx == IDX_CHOP && wb_sel_i == 4'hf
    |=> chopper_config == $past(wb_dat_i))
    else $error("chopper config write lost");
  a_vchp_no_read: assert property (acc && !wb_we_i && idx == IDX_VCHP |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("write-only register returned data");
  a_vchp_write: assert property (wr && idx == IDX_VCHP && wb_sel_i != 4'h0
    |=> voltage_chopper_cfg == $past(wb_dat_i[21:0]))
    else $error("voltage chopper config write lost");
  // Table start values; the reset edge itself is skipped
  a_phase_b_offset: assert property ($past(rst_b) && $past(microstep_pos) == 10'h000
    |-> phase_b_current == 9'sh0f7)
    else $error("phase B not offset by 256");
  a_phase_a_start: assert property ($past(rst_b) && $past(microstep_pos) == 10'h000
    |-> phase_a_current == 9'sh000)
    else $error("phase A start entry wrong");
  a_scale_unused: assert property (acc && !wb_we_i && idx == IDX_SCALE |=> wb_dat_o[15:8] == 8'h00)
    else $error("unused bits not zero");
  // Load-speed gating and step accounting
  a_vel_enable: assert property (vmin_cfg != '0 && actual_velocity >= vmin_cfg |=> load_speed_active)
    else $error("load-speed mode not enabled by velocity");
  a_skip_pos_hold: assert property (skip_evt |=> $stable(microstep_pos))
    else $error("position moved on a skipped step");
  a_skip_load_gate: assert property (!load_speed_active |=> $stable(skipped))
    else $error("skipped counter moved outside load-speed mode");
  a_skip_count_down: assert property (skip_evt && pin_q[3] && pin_q[1]
    |=> skipped == $past(skipped) - 1'b1)
    else $error("skipped counter did not count down");
  a_comm_inactive: assert property (!load_speed_active |=> !commutation_limit && !stall_detected)
    else $error("on-time pulse outside load-speed mode");
  a_on_cnt_clear: assert property (!pwm_on |=> on_cnt == '0)
    else $error("on-time counter not cleared in off phase");
  a_stall_on_time: assert property (stall_detected |-> $past(on_cnt) == $past(sg_limit))
    else $error("stall pulse at wrong on-time");

  c_skipped_step: cover property (skip_evt && pin_q[3]);
  c_stall_event:  cover property (stall_detected ##1 irq);
  c_comm_limit:   cover property (commutation_limit);
  c_vel_trigger:  cover property (!pin_q[2] && load_speed_active);
  c_skip_down:    cover property (skip_evt && pin_q[3] && pin_q[1]);

endmodule

`default_nettype wire

// *** tb/stp_motor_side.sv ***
// Purpose: Far-side step source for the stepper register bench
// Assumes: Step and direction pins pass a synchroniser in the block
// Notes:   Each level is held four clocks, above the two-clock minimum
`timescale 1ns/1ps
`default_nettype none
module stp_motor_side
(
  // Clock
  input  wire logic mclk,
  // Step pins
  output var  logic step_pin,
  output var  logic dir_pin
);
  // Idle levels before the first pulse
  initial
  begin
    step_pin = 1'b0;
    dir_pin  = 1'b0;
  end
  // Direction settles well before the rising step edge
  task automatic pulse(input logic d);
    @(posedge mclk);
    dir_pin <= d;
    repeat (4) @(posedge mclk);
    step_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    step_pin <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** tb/stp_regs_tb_top.sv ***
// Purpose: Self-checking bench of the stepper driver register set
// Assumes: Wishbone classic master, one step source partner
// Notes:   Read data and positions are checked from queues by monitors
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module stp_regs_tb_top;
  import stp_pkg::*;
  logic              mclk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, step_pin, dir_pin, wb_ack_o, irq;
  logic              load_speed_enable_pin, step_dir_mode_select, pwm_on, load_speed_output;
  logic              load_speed_active, commutation_limit, stall_detected;
  logic [8:0]        wb_adr_i, duty_offset_auto;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o, driver_status_in, chopper_config, r, s, ev;
  logic [VEL_W-1:0]  actual_velocity;
  logic [7:0]        duty_cycle_sum, auto_amplitude_offset, auto_amplitude_gradient;
  logic [24:0]       load_adaptive_current_cfg;
  logic [21:0]       voltage_chopper_cfg;
  logic signed [8:0] phase_a_current, phase_b_current, scaled_a, scaled_b;
  logic [9:0]        microstep_pos, last_pos;
  logic [31:0]       rd_q[$];
  int                pos_q[$];
  int                err_count, cmp_count, pos, cur, e, dc, ds;
  bit                ph_chk;

  stp_regs DUT (.mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .step_pin, .dir_pin, .load_speed_enable_pin, .step_dir_mode_select,
    .pwm_on, .load_speed_output, .actual_velocity, .duty_cycle_sum, .duty_offset_auto,
    .auto_amplitude_offset, .auto_amplitude_gradient, .driver_status_in, .chopper_config,
    .load_adaptive_current_cfg, .voltage_chopper_cfg, .load_speed_active, .commutation_limit,
    .stall_detected, .phase_a_current, .phase_b_current, .scaled_a, .scaled_b, .microstep_pos, .irq);
  stp_motor_side P (.mclk, .step_pin, .dir_pin);

  // 10 MHz clock
  always #50 mclk = ~mclk;

  // Reference sine, negative half mirrored as inverse
  function automatic logic signed [8:0] sine_ref(input int i);
    real x;
    int  v;
    x = 248.0 * $sin(2.0 * 3.141592653589793 * (i % 512) / 1024.0 + 3.141592653589793 / 1024.0);
    v = int'($floor(x + 0.5)) - 1;
    if (i >= 512) v = -v - 1;
    return v[8:0];
  endfunction

  // Read data monitor, oldest note first
  always @(posedge mclk)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      ev = (rd_q.size() > 0) ? rd_q.pop_front() : 32'hdead_beef;
      `CHK("rd_data", ev, wb_dat_o)
    end
  end

  // Position monitor, phase currents follow one edge after the position
  always @(posedge mclk)
  begin
    if (ph_chk)
    begin
      `CHK("phase_a", sine_ref(cur), phase_a_current)
      `CHK("phase_b", sine_ref((cur + 256) % 1024), phase_b_current)
    end
    ph_chk = 1'b0;
    if (rst_b === 1'b1 && microstep_pos !== last_pos)
    begin
      cur = (pos_q.size() > 0) ? pos_q.pop_front() : -1;
      `CHK("pos", cur[9:0], microstep_pos)
      ph_chk = 1'b1;
    end
    last_pos = microstep_pos;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [6:0] idx, input logic [31:0] d);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      close_out();
    end
  endtask

  task automatic rd(input logic [6:0] idx, input logic [31:0] x);
    rd_q.push_back(x);
    wb(1'b0, idx, 32'h0000_0000);
  endtask

  // Skipped steps leave the position alone
  task automatic stp(input logic d, input bit skip);
    if (!skip)
    begin
      pos = d ? (pos + 1023) % 1024 : (pos + 1) % 1024;
      pos_q.push_back(pos);
    end
    P.pulse(d);
  endtask

  // One chopper on phase, delays of both pulses from its start
  task automatic burst();
    dc = -1;
    ds = -1;
    @(posedge mclk);
    pwm_on <= 1'b1;
    for (int k = 1; k < 80; k++)
    begin
      @(posedge mclk);
      if (commutation_limit === 1'b1 && dc < 0) dc = k;
      if (stall_detected === 1'b1 && ds < 0) ds = k;
    end
    pwm_on <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  initial
  begin
    {mclk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, pwm_on, load_speed_enable_pin, step_dir_mode_select} = '0;
    {wb_adr_i, wb_dat_i, actual_velocity, duty_cycle_sum, duty_offset_auto} = '0;
    {auto_amplitude_offset, auto_amplitude_gradient, driver_status_in} = '0;
    {err_count, cmp_count, pos, ph_chk, last_pos} = '0;
    load_speed_output = 1'b1;
    wb_sel_i = 4'hf;
    void'($urandom(97960));
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("chop_rst", CHOP_RST, chopper_config)
    `CHK("vchp_rst", VCHP_RST[21:0], voltage_chopper_cfg)
    `CHK("phase_a0", sine_ref(0), phase_a_current)
    `CHK("phase_b0", sine_ref(256), phase_b_current)
    rd(IDX_CHOP, CHOP_RST);
    rd(IDX_VCHP, 32'h0000_0000);
    rd(7'h7f, 32'h0000_0000);
    $display("test reset done");
    // Register access and live read-back values
    r = $urandom;
    wb(1'b1, IDX_CHOP, r);
    rd(IDX_CHOP, r);
    r = $urandom;
    wb(1'b1, IDX_VCHP, r);
    `CHK("vchp", r[21:0], voltage_chopper_cfg)
    wb(1'b1, IDX_COOL, ~r);
    `CHK("cool", ~r[24:0], load_adaptive_current_cfg)
    s = $urandom;
    duty_cycle_sum <= s[7:0];
    duty_offset_auto <= s[16:8];
    auto_amplitude_offset <= s[23:16];
    auto_amplitude_gradient <= s[31:24];
    driver_status_in <= r;
    wb(1'b1, IDX_SCALE, 32'hffff_ffff);
    rd(IDX_SCALE, {7'h00, s[16:8], 8'h00, s[7:0]});
    rd(IDX_AUTO, {8'h00, s[31:24], 8'h00, s[23:16]});
    rd(IDX_DRV, r);
    rd(IDX_ACOM, 32'h0000_0000);
    $display("test registers done");
    // Forward across the wrap, then back again
    for (int k = 0; k < 1100; k++) stp(k >= 1040, 1'b0);
    repeat (3) @(posedge mclk);
    e = (int'(sine_ref(pos)) * int'(duty_cycle_sum)) >>> 8;
    `CHK("scaled_a", e[8:0], scaled_a)
    e = (int'(sine_ref((pos + 256) % 1024)) * int'(duty_cycle_sum)) >>> 8;
    `CHK("scaled_b", e[8:0], scaled_b)
    $display("test steps done");
    // Skipped steps under load, counted both ways with wrap
    load_speed_enable_pin <= 1'b1;
    load_speed_output <= 1'b0;
    step_dir_mode_select <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK("ls_pin", 1'b1, load_speed_active)
    for (int k = 0; k < 8; k++) stp(k >= 3, 1'b1);
    rd(IDX_SKIP, 32'h000f_fffe);
    `CHK("irq_masked", 1'b0, irq)
    rd(IDX_ISTAT, 32'h0000_0004);
    wb(1'b1, IDX_IMASK, 32'h0000_0004);
    repeat (2) @(posedge mclk);
    `CHK("irq_set", 1'b1, irq)
    step_dir_mode_select <= 1'b0;
    repeat (8) @(posedge mclk);
    stp(1'b0, 1'b1);
    rd(IDX_SKIP, 32'h000f_fffe);
    wb(1'b1, IDX_ISTAT, 32'h0000_0004);
    repeat (2) @(posedge mclk);
    `CHK("irq_clr", 1'b0, irq)
    $display("test skipped done");
    // Limit 5 kept above blank time, stall 16 above limit/16
    load_speed_output <= 1'b1;
    wb(1'b1, IDX_ACOM, 32'h0001_0005);
    burst();
    `CHK("comm_time", 7, dc)
    `CHK("stall_gap", 11, ds - dc)
    wb(1'b1, IDX_ACOM, 32'h0000_0005);
    burst();
    `CHK("stall_off", -1, ds)
    wb(1'b1, IDX_ACOM, 32'h0001_0005);
    actual_velocity <= 23'd200;
    wb(1'b1, IDX_HVTH, 32'h0000_0032);
    burst();
    `CHK("stall_hv", -1, ds)
    wb(1'b1, IDX_HVTH, 32'h0080_0032);
    burst();
    `CHK("stall_hvfs", 11, ds - dc)
    $display("test on_time done");
    // Velocity trigger alone
    load_speed_enable_pin <= 1'b0;
    wb(1'b1, IDX_VMIN, 32'h0000_0064);
    repeat (8) @(posedge mclk);
    `CHK("ls_vel", 1'b1, load_speed_active)
    actual_velocity <= 23'd50;
    repeat (3) @(posedge mclk);
    `CHK("ls_slow", 1'b0, load_speed_active)
    $display("test velocity done");
    close_out();
  end
endmodule
`default_nettype wire
